// ### design/sac_top.v
// root command interpreter: digitize, run/stop, pixel memories, limit fail, serial
`timescale 1ns/1ps
`include "sac_defs.vh"
module sac_top (
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire [3:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  input  wire        trigger_i,
  input  wire        limit_fail_i,
  input  wire        protect_open_i,
  input  wire [1:0]  sweep_mode_setting_i,
  input  wire [7:0]  sample_i,
  output reg  [31:0] rdata_o,
  output reg  [3:0]  chan_capture_o,
  output reg         acquiring_o,
  output reg         srq_o,
  output reg         cmd_error_o,
  output reg         serial_commit_o
);
  // one-hot digitize sequencer states
  localparam ST_IDLE  = 3'b001;
  localparam ST_FIRST = 3'b010;
  localparam ST_PAIR2 = 3'b100;
  // trigger, limit-fail and protect pins pass two flops
  reg  [1:0]  trig_s_r;
  reg  [1:0]  lim_s_r;
  reg  [1:0]  prot_s_r;
  reg         trig_d_r;
  wire        trig_edge = trig_s_r[1] & ~trig_d_r;
  reg  [2:0]  dig_st_r;
  reg  [3:0]  dig_sel_r;
  reg  [3:0]  second_r;
  reg         running_r;
  reg         resume_r;
  reg         single_done_r;
  reg         lim_bit_r;
  reg  [3:0]  chan_on_r;
  reg  [1:0]  func_on_r;
  reg  [3:0]  wmem_on_r;
  reg  [2:0]  pmem_on_r;
  reg  [31:0] reply_r;
  reg  [79:0] serial_r;
  reg  [79:0] ser_stage_r;
  reg  [3:0]  ser_cnt_r;
  reg  [3:0]  buf_addr_r;
  reg  [3:0]  mem_raddr_r;
  reg  [1:0]  mem_rsel_r;
  reg         pm_erase_r;
  reg         pm_merge_r;
  reg  [1:0]  pm_sel_r;
  wire [7:0]  pm_rdata;
  wire        pm_busy;
  wire        cmd_wr = wr_i && (addr_i == `SAC_REG_CMD);
  wire [3:0]  op  = wdata_i[3:0];
  wire [3:0]  arg = wdata_i[7:4];
  wire [3:0]  cls = wdata_i[11:8];
  wire [3:0]  dmask = wdata_i[15:12];
  // serial character rides in the top byte, clear of the opcode field
  wire [7:0]  ch = wdata_i[`SAC_CHAR_MSB:`SAC_CHAR_LSB];
  wire        ch_ok = ((ch >= `SAC_CHAR_0) && (ch <= `SAC_CHAR_9)) ||
                      ((ch >= `SAC_CHAR_A) && (ch <= `SAC_CHAR_Z));
  // both members of a shared converter selected
  wire        pair_a = dig_sel_r[0] & dig_sel_r[1];
  wire        pair_b = dig_sel_r[2] & dig_sel_r[3];
  // the member of a shared pair listed second waits for a trigger of its own
  reg  [3:0]  second_nxt;
  always @* begin
    second_nxt = 4'h0;
    if (dmask[0] & dmask[1])
      second_nxt = second_nxt | (wdata_i[`SAC_ORD_A_BIT] ? 4'h1 : 4'h2);
    if (dmask[2] & dmask[3])
      second_nxt = second_nxt | (wdata_i[`SAC_ORD_B_BIT] ? 4'h4 : 4'h8);
  end
  reg         arg_ok;
  reg         src_on;
  always @* begin
    arg_ok = 1'b0;
    src_on = 1'b0;
    case (cls)
      `SAC_CLS_CHAN: begin
        arg_ok = (arg >= 4'h1) && (arg <= 4'h4);
        src_on = arg_ok && chan_on_r[arg[1:0] - 2'h1];
      end
      `SAC_CLS_FUNC: begin
        arg_ok = (arg >= 4'h1) && (arg <= 4'h2);
        src_on = arg_ok && func_on_r[arg[0] ? 1'b0 : 1'b1];
      end
      `SAC_CLS_WMEM: begin
        arg_ok = (arg >= 4'h1) && (arg <= 4'h4);
        src_on = arg_ok && wmem_on_r[arg[1:0] - 2'h1];
      end
      `SAC_CLS_PMEM: begin
        arg_ok = (arg <= 4'h2);
        src_on = arg_ok && pmem_on_r[arg[1:0]];
      end
      default: begin
        arg_ok = 1'b0;
        src_on = 1'b0;
      end
    endcase
  end
  // one sample buffer per channel, filled on that channel's capture pulse
  wire [31:0] chbuf_rd;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_chbuf
      reg [7:0] buf_r [0:15];
      always @(posedge clk_i) begin
        if (chan_capture_o[g])
          buf_r[buf_addr_r] <= sample_i;
      end
      assign chbuf_rd[8*g +: 8] = buf_r[mem_raddr_r];
    end
  endgenerate
  // serial byte chosen by the latched word address; past the tenth reads zero
  reg  [7:0]  ser_byte;
  always @* begin
    ser_byte = 8'h00;
    if (mem_raddr_r < `SAC_SER_CHARS)
      ser_byte = serial_r[8*mem_raddr_r +: 8];
  end
  always @(posedge clk_i) begin
    if (reset_i) begin
      trig_s_r       <= 2'h0;
      lim_s_r        <= 2'h0;
      prot_s_r       <= 2'h0;
      trig_d_r       <= 1'b0;
      dig_st_r       <= ST_IDLE;
      dig_sel_r      <= 4'h0;
      second_r       <= 4'h0;
      running_r      <= 1'b0;
      resume_r       <= 1'b0;
      single_done_r  <= 1'b0;
      lim_bit_r      <= 1'b0;
      chan_on_r      <= 4'hF;
      func_on_r      <= 2'h0;
      wmem_on_r      <= 4'h0;
      pmem_on_r      <= 3'h1;
      reply_r        <= 32'h0000_0000;
      serial_r       <= 80'h0;
      ser_stage_r    <= 80'h0;
      ser_cnt_r      <= 4'h0;
      buf_addr_r     <= 4'h0;
      mem_raddr_r    <= 4'h0;
      mem_rsel_r     <= 2'h0;
      pm_erase_r     <= 1'b0;
      pm_merge_r     <= 1'b0;
      pm_sel_r       <= 2'h0;
      rdata_o        <= 32'h0000_0000;
      chan_capture_o <= 4'h0;
      acquiring_o    <= 1'b0;
      srq_o          <= 1'b0;
      cmd_error_o    <= 1'b0;
      serial_commit_o <= 1'b0;
    end else begin
      trig_s_r <= {trig_s_r[0], trigger_i};
      lim_s_r  <= {lim_s_r[0], limit_fail_i};
      prot_s_r <= {prot_s_r[0], protect_open_i};
      trig_d_r <= trig_s_r[1];
      pm_erase_r      <= 1'b0;
      pm_merge_r      <= 1'b0;
      cmd_error_o     <= 1'b0;
      serial_commit_o <= 1'b0;
      srq_o           <= 1'b0;
      chan_capture_o  <= 4'h0;
      if (chan_capture_o != 4'h0)
        buf_addr_r <= buf_addr_r + 4'h1;
      // set wins over a clear in the same cycle
      if (lim_s_r[1] && !lim_bit_r) begin
        lim_bit_r <= 1'b1;
        srq_o     <= 1'b1;
      end else if (cmd_wr && op == `SAC_OP_LTERQ) begin
        lim_bit_r <= 1'b0;
      end
      // digitize sequencer
      case (dig_st_r)
        ST_IDLE: begin
          if (running_r && trig_edge && !(single_done_r &&
              sweep_mode_setting_i == `SAC_SWEEP_SINGLE)) begin
            chan_capture_o <= chan_on_r;
            buf_addr_r     <= 4'h0;
            if (sweep_mode_setting_i == `SAC_SWEEP_SINGLE)
              single_done_r <= 1'b1;
          end
        end
        ST_FIRST: begin
          if (trig_edge) begin
            chan_capture_o <= dig_sel_r & ~second_r;
            buf_addr_r     <= 4'h0;
            if (pair_a || pair_b) begin
              dig_st_r <= ST_PAIR2;
            end else begin
              dig_st_r    <= ST_IDLE;
              running_r   <= 1'b0;
              acquiring_o <= 1'b0;
            end
          end
        end
        ST_PAIR2: begin
          if (trig_edge) begin
            chan_capture_o <= second_r;
            buf_addr_r     <= 4'h0;
            dig_st_r       <= ST_IDLE;
            running_r      <= 1'b0;
            acquiring_o    <= 1'b0;
          end
        end
        default: dig_st_r <= ST_IDLE;
      endcase
      // resume acquisition once the memory 0 wipe finishes
      if (resume_r && !pm_busy && !pm_erase_r) begin
        resume_r    <= 1'b0;
        running_r   <= 1'b1;
        acquiring_o <= 1'b1;
      end
      if (cmd_wr) begin
        case (op)
          `SAC_OP_DIGITIZE: begin
            // an empty channel list has nothing to digitize
            if (dmask == 4'h0) begin
              cmd_error_o <= 1'b1;
            end else begin
              dig_sel_r   <= dmask;
              chan_on_r   <= dmask;
              // channel listed first in the argument order goes first
              second_r    <= second_nxt;
              dig_st_r    <= ST_FIRST;
              running_r   <= 1'b1;
              acquiring_o <= 1'b1;
            end
          end
          `SAC_OP_RUN: begin
            running_r     <= 1'b1;
            single_done_r <= 1'b0;
            acquiring_o   <= 1'b1;
          end
          `SAC_OP_STOP: begin
            running_r   <= 1'b0;
            acquiring_o <= 1'b0;
            resume_r    <= 1'b0;
            dig_st_r    <= ST_IDLE;
          end
          `SAC_OP_CLEAR: begin
            dig_st_r    <= ST_IDLE;
            second_r    <= 4'h0;
            running_r   <= 1'b0;
            acquiring_o <= 1'b0;
            ser_cnt_r   <= 4'h0;
          end
          `SAC_OP_ERASE: begin
            if (cls != `SAC_CLS_PMEM || !arg_ok || pm_busy) begin
              cmd_error_o <= 1'b1;
            end else begin
              pm_erase_r <= 1'b1;
              pm_sel_r   <= arg[1:0];
              // live samples must not land in memory 0 while it is wiped
              if (arg == 4'h0 && running_r) begin
                running_r   <= 1'b0;
                acquiring_o <= 1'b0;
                resume_r    <= 1'b1;
              end
            end
          end
          `SAC_OP_MERGE: begin
            if (cls != `SAC_CLS_PMEM || arg == 4'h0 || !arg_ok || pm_busy) begin
              cmd_error_o <= 1'b1;
            end else begin
              pm_merge_r <= 1'b1;
              pm_sel_r   <= arg[1:0];
            end
          end
          `SAC_OP_RUNQ: reply_r <= {31'h0, running_r};
          `SAC_OP_LTERQ: reply_r <= {31'h0, lim_bit_r};
          `SAC_OP_STATQ: begin
            // status reads leave every on/off flag untouched
            if (!arg_ok)
              cmd_error_o <= 1'b1;
            else
              reply_r <= {31'h0, src_on};
          end
          `SAC_OP_SERIAL: begin
            // a bad character restarts entry so a short string never commits
            if (!ch_ok) begin
              cmd_error_o <= 1'b1;
              ser_cnt_r   <= 4'h0;
            end else if (ser_cnt_r == 4'h9) begin
              ser_cnt_r <= 4'h0;
              if (prot_s_r[1]) begin
                serial_r        <= {ser_stage_r[71:0], ch};
                serial_commit_o <= 1'b1;
              end else begin
                cmd_error_o <= 1'b1;
              end
            end else begin
              ser_stage_r <= {ser_stage_r[71:0], ch};
              ser_cnt_r   <= ser_cnt_r + 4'h1;
            end
          end
          `SAC_OP_IDNQ: reply_r <= `SAC_ID_CODE; // arbitrary identity value
          default: cmd_error_o <= 1'b1;
        endcase
      end
      if (wr_i && addr_i == `SAC_REG_MEMADDR) begin
        mem_raddr_r <= wdata_i[3:0];
        mem_rsel_r  <= wdata_i[5:4];
      end
      // read data stands for one cycle only, zero otherwise
      rdata_o <= 32'h0000_0000;
      if (rd_i) begin
        case (addr_i)
          `SAC_REG_STATE:   rdata_o <= {26'h0, lim_bit_r, pm_busy, dig_st_r[0],
                                        resume_r, 1'b0, running_r};
          `SAC_REG_SRC_ON:  rdata_o <= {19'h0, pmem_on_r, wmem_on_r, func_on_r, chan_on_r};
          `SAC_REG_REPLY:   rdata_o <= reply_r;
          // serial word index chosen by low bits of the latched memory address
          `SAC_REG_SERIAL:  rdata_o <= {24'h0, ser_byte};
          `SAC_REG_IDN:     rdata_o <= {24'h0, serial_r[7:0]};
          `SAC_REG_MEMWORD: rdata_o <= {16'h0, chbuf_rd[8*mem_rsel_r +: 8], pm_rdata};
          `SAC_REG_MEMADDR: rdata_o <= {26'h0, mem_rsel_r, mem_raddr_r};
          default:          rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end
  // the active memory takes samples only while no erase or combine walks it
  sac_pixel_mem u_pmem (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .wr_i      (running_r && trig_edge && !pm_busy),
    .wr_addr_i (buf_addr_r),
    .wr_data_i (sample_i),
    .erase_i   (pm_erase_r),
    .merge_i   (pm_merge_r),
    .sel_i     (pm_sel_r),
    .rd_mem_i  (mem_rsel_r),
    .rd_addr_i (mem_raddr_r),
    .rd_data_o (pm_rdata),
    .busy_o    (pm_busy)
  );
endmodule // sac_top

// ### design/sac_defs.vh
// command codes, field layouts and constants for the acquisition command block
`ifndef SAC_DEFS_VH
`define SAC_DEFS_VH
`define SAC_ADDR_W        4
`define SAC_REG_CMD       4'h0
`define SAC_REG_STATE     4'h1
`define SAC_REG_SRC_ON    4'h2
`define SAC_REG_REPLY     4'h3
`define SAC_REG_SERIAL    4'h4
`define SAC_REG_IDN       4'h5
`define SAC_REG_MEMWORD   4'h6
`define SAC_REG_MEMADDR   4'h7
// command word: [3:0] opcode, [7:4] argument index, [11:8] source class,
// [15:12] digitize mask, [16]/[17] pair order, [31:24] serial character
`define SAC_OP_DIGITIZE   4'h1
`define SAC_OP_RUN        4'h2
`define SAC_OP_STOP       4'h3
`define SAC_OP_ERASE      4'h4
`define SAC_OP_MERGE      4'h5
`define SAC_OP_RUNQ       4'h6
`define SAC_OP_LTERQ      4'h7
`define SAC_OP_STATQ      4'h8
`define SAC_OP_SERIAL     4'h9
`define SAC_OP_IDNQ       4'hA
`define SAC_OP_CLEAR      4'hB
`define SAC_CLS_CHAN      4'h0
`define SAC_CLS_FUNC      4'h1
`define SAC_CLS_WMEM      4'h2
`define SAC_CLS_PMEM      4'h3
`define SAC_SWEEP_SINGLE  2'h0
`define SAC_MEM_AW        4
`define SAC_MEM_DEPTH     16
`define SAC_SER_CHARS     10
`define SAC_CHAR_0        8'h30
`define SAC_CHAR_9        8'h39
`define SAC_CHAR_A        8'h41
`define SAC_CHAR_Z        8'h5A
`define SAC_ORD_A_BIT     16
`define SAC_ORD_B_BIT     17
`define SAC_CHAR_MSB      31
`define SAC_CHAR_LSB      24
// arbitrary identity value
`define SAC_ID_CODE       32'h00C0FFEE
`endif

// ### design/sac_pixel_mem.v
// three pixel memories with erase and combine sequencer
`timescale 1ns/1ps
`include "sac_defs.vh"
module sac_pixel_mem (
  input  wire        clk_i,
  input  wire        reset_i,
  input  wire        wr_i,
  input  wire [3:0]  wr_addr_i,
  input  wire [7:0]  wr_data_i,
  input  wire        erase_i,
  input  wire        merge_i,
  input  wire [1:0]  sel_i,
  input  wire [1:0]  rd_mem_i,
  input  wire [3:0]  rd_addr_i,
  output reg  [7:0]  rd_data_o,
  output reg         busy_o
);
  reg [7:0] mem0 [0:15];
  reg [7:0] mem1 [0:15];
  reg [7:0] mem2 [0:15];
  reg [3:0] idx_r;
  reg       do_erase_r;
  reg [1:0] tgt_r;
  always @(posedge clk_i) begin
    if (reset_i) begin
      busy_o     <= 1'b0;
      idx_r      <= 4'h0;
      do_erase_r <= 1'b0;
      tgt_r      <= 2'h0;
      rd_data_o  <= 8'h00;
    end else begin
      case (rd_mem_i)
        2'h0:    rd_data_o <= mem0[rd_addr_i];
        2'h1:    rd_data_o <= mem1[rd_addr_i];
        2'h2:    rd_data_o <= mem2[rd_addr_i];
        default: rd_data_o <= 8'h00;
      endcase
      if (!busy_o && (erase_i || merge_i)) begin
        busy_o     <= 1'b1;
        idx_r      <= 4'h0;
        do_erase_r <= erase_i;
        tgt_r      <= sel_i;
      end else if (busy_o) begin
        if (idx_r == 4'hF)
          busy_o <= 1'b0;
        idx_r <= idx_r + 4'h1;
      end
    end
  end
  // memory arrays carry no reset; erase walks every word
  always @(posedge clk_i) begin
    if (busy_o && do_erase_r) begin
      if (tgt_r == 2'h0)
        mem0[idx_r] <= 8'h00;
      if (tgt_r == 2'h1)
        mem1[idx_r] <= 8'h00;
      if (tgt_r == 2'h2)
        mem2[idx_r] <= 8'h00;
    end else if (busy_o) begin
      if (tgt_r == 2'h1)
        mem1[idx_r] <= mem1[idx_r] | mem0[idx_r];
      if (tgt_r == 2'h2)
        mem2[idx_r] <= mem2[idx_r] | mem0[idx_r];
    end else if (wr_i) begin
      mem0[wr_addr_i] <= mem0[wr_addr_i] | wr_data_i;
    end
  end
endmodule // sac_pixel_mem

// ### sim/sac_front_end.sv
// acquisition front end model: trigger pin and sample stream
`timescale 1ns/1ps
module sac_front_end (
  input  wire       clk_i,
  input  wire       fire_i,
  output reg        trigger_o,
  output reg  [7:0] sample_o
);
  reg [2:0] hold_r;
  initial begin
    trigger_o = 1'b0;
    sample_o  = 8'hA5;
    hold_r    = 3'h0;
  end
  // pin held high several cycles so the input synchroniser cannot miss it
  always @(posedge clk_i) begin
    sample_o <= {sample_o[6:0], sample_o[7] ^ sample_o[5]};
    if (fire_i) hold_r <= 3'h6;
    else if (hold_r != 3'h0) hold_r <= hold_r - 3'h1;
    trigger_o <= fire_i || (hold_r > 3'h1);
  end
endmodule // sac_front_end

// ### sim/sac_top_chk.sv
// concurrent checks on the acquisition command block ports
`timescale 1ns/1ps
`include "sac_defs.vh"
module sac_chk (
  input wire        clk_i,
  input wire        reset_i,
  input wire [3:0]  addr_i,
  input wire [31:0] wdata_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire        trigger_i,
  input wire        protect_open_i,
  input wire [31:0] rdata_o,
  input wire [3:0]  chan_capture_o,
  input wire        acquiring_o,
  input wire        srq_o,
  input wire        cmd_error_o,
  input wire        serial_commit_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  reg        trig_q_r;
  reg  [3:0] since_r;
  wire       cmd_w = wr_i && addr_i == `SAC_REG_CMD;
  wire [3:0] op_w = wdata_i[3:0];
  wire [3:0] ix_w = wdata_i[7:4];
  // saturating count of edges since the pin rose, so idle spans never wrap
  always @(posedge clk_i) begin
    trig_q_r <= trigger_i;
    if (reset_i) since_r <= 4'hF;
    else if (trigger_i && !trig_q_r) since_r <= 4'h0;
    else if (since_r != 4'hF) since_r <= since_r + 4'h1;
  end
  property p_rd_idle; !rd_i |=> rdata_o == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer");
  property p_srq_once; srq_o |=> !srq_o; endproperty
  a_srq_once: assert property (p_srq_once) else $error("service request too long");
  property p_bad_arg;
    cmd_w && (op_w == `SAC_OP_ERASE && ix_w > 4'h2 ||
              op_w == `SAC_OP_MERGE && (ix_w == 4'h0 || ix_w > 4'h2)) |-> ##[1:3] cmd_error_o;
  endproperty
  a_bad_arg: assert property (p_bad_arg) else $error("bad index not refused");
  property p_commit; serial_commit_o |-> protect_open_i; endproperty
  a_commit: assert property (p_commit) else $error("serial stored while protected");
  property p_pair; chan_capture_o[1:0] != 2'h3 && chan_capture_o[3:2] != 2'h3; endproperty
  a_pair: assert property (p_pair) else $error("shared pair captured together");
  property p_cap_trig; chan_capture_o != 4'h0 |-> since_r < 4'hC; endproperty
  a_cap_trig: assert property (p_cap_trig) else $error("capture without trigger");
  property p_run; cmd_w && op_w == `SAC_OP_RUN |-> ##[1:3] acquiring_o; endproperty
  a_run: assert property (p_run) else $error("run did not start");
  property p_stop; cmd_w && op_w == `SAC_OP_STOP |-> ##[1:3] !acquiring_o; endproperty
  a_stop: assert property (p_stop) else $error("stop did not halt");
  property p_clear;
    cmd_w && op_w == `SAC_OP_CLEAR |=> (chan_capture_o == 4'h0) [*8];
  endproperty
  a_clear: assert property (p_clear) else $error("capture after clear");
  c_simul: cover property (chan_capture_o == 4'h5);
  c_srq: cover property (srq_o);
  c_commit: cover property (serial_commit_o);
endmodule // sac_chk
bind sac_top sac_chk u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .trigger_i(trigger_i), .protect_open_i(protect_open_i), .rdata_o(rdata_o),
  .chan_capture_o(chan_capture_o), .acquiring_o(acquiring_o), .srq_o(srq_o),
  .cmd_error_o(cmd_error_o), .serial_commit_o(serial_commit_o)
);

// ### sim/tb_sac_top.sv
// self-checking bench for the acquisition command block
`timescale 1ns/1ps
`include "sac_defs.vh"
module tb_sac_top;
  reg          clk_i = 1'b0;
  reg          reset_i = 1'b1;
  reg  [3:0]   addr_i = 4'h0;
  reg  [31:0]  wdata_i = 32'h0;
  reg          wr_i = 1'b0;
  reg          rd_i = 1'b0;
  reg          fire = 1'b0;
  reg          limit_fail_i = 1'b0;
  reg          protect_open_i = 1'b0;
  reg  [1:0]   sweep_mode_setting_i = 2'h0;
  wire         trigger_i;
  wire [7:0]   sample_i;
  wire [31:0]  rdata_o;
  wire [3:0]   chan_capture_o;
  wire         acquiring_o;
  wire         srq_o;
  wire         cmd_error_o;
  wire         serial_commit_o;
  int          mismatches = 0;
  int          comparisons = 0;
  logic [63:0] rd_q[$];
  logic [63:0] rx;
  logic [7:0]  ev_q[$];
  logic [7:0]  obs;
  logic [7:0]  ch;
  logic        rd_pend = 1'b0;
  sac_front_end u_fe (.clk_i(clk_i), .fire_i(fire), .trigger_o(trigger_i), .sample_o(sample_i));
  sac_top DUT (
    .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .trigger_i(trigger_i), .limit_fail_i(limit_fail_i),
    .protect_open_i(protect_open_i), .sweep_mode_setting_i(sweep_mode_setting_i),
    .sample_i(sample_i), .rdata_o(rdata_o), .chan_capture_o(chan_capture_o),
    .acquiring_o(acquiring_o), .srq_o(srq_o), .cmd_error_o(cmd_error_o),
    .serial_commit_o(serial_commit_o)
  );
  initial forever #10 clk_i = ~clk_i;
  task automatic stop_test;
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g, input logic [31:0] m);
    comparisons++;
    if ((g & m) !== (e & m)) begin
      mismatches++;
      $display("[ERR] rdata exp %h got %h", e & m, g & m);
    end
  endtask
  task automatic cmp_ev(input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] event exp %h got %h", e, g);
    end
  endtask
  // outputs seen at the edge hold what the previous cycle settled to
  always @(posedge clk_i) begin
    if (rd_pend) begin
      rx = rd_q.pop_front();
      cmp_rd(rx[31:0], rdata_o, rx[63:32]);
    end
    rd_pend <= rd_i;
    obs = {1'b0, serial_commit_o, cmd_error_o, srq_o, chan_capture_o};
    if (!reset_i && obs != 8'h00) cmp_ev(ev_q.size() ? ev_q.pop_front() : 8'h00, obs);
  end
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    rd_q.push_back({m, e});
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask
  function automatic logic [31:0] c(input logic [3:0] op, input logic [3:0] ix,
                                    input logic [3:0] cl);
    return {20'h0, cl, ix, op};
  endfunction
  task automatic cmd(input logic [31:0] d);
    wr(`SAC_REG_CMD, d);
  endtask
  task automatic q(input logic [31:0] d, input logic [31:0] e);
    cmd(d);
    rd(`SAC_REG_REPLY, e, 32'hFFFFFFFF);
  endtask
  task automatic dig(input logic [3:0] mk, input logic [1:0] od);
    cmd({14'h0, od, mk, 8'h00, `SAC_OP_DIGITIZE});
  endtask
  task automatic settle;
    for (int i = 0; i < 40 && ev_q.size() > 0; i++) @(posedge clk_i);
    if (ev_q.size() > 0) cmp_ev(ev_q.pop_front(), 8'h00);
    repeat (8) @(posedge clk_i);
  endtask
  task automatic trig;
    @(posedge clk_i);
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    settle();
  endtask
  task automatic fail;
    @(posedge clk_i);
    limit_fail_i <= 1'b1;
    repeat (2 + $urandom % 4) @(posedge clk_i);
    limit_fail_i <= 1'b0;
    settle();
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    stop_test();
  end
  initial begin
    void'($urandom(25));
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(`SAC_REG_STATE, 32'h0, 32'h1);
    rd(4'h8, 32'h0, 32'hFFFFFFFF);
    repeat (2) q(c(`SAC_OP_STATQ, 0, `SAC_CLS_PMEM), 1);
    q(c(`SAC_OP_STATQ, 2, `SAC_CLS_FUNC), 0);
    q(c(`SAC_OP_STATQ, 4, `SAC_CLS_WMEM), 0);
    rd(`SAC_REG_SRC_ON, 32'h40F, 32'hFFFFFFFF);
    ev_q.push_back(8'h20);
    cmd(c(`SAC_OP_STATQ, 5, `SAC_CLS_CHAN));
    settle();
    for (int m = 0; m < 2; m++) begin
      sweep_mode_setting_i <= m[1:0];
      cmd(c(`SAC_OP_RUN, 0, 0));
      q(c(`SAC_OP_RUNQ, 0, 0), 1);
      cmd(c(`SAC_OP_STOP, 0, 0));
      q(c(`SAC_OP_RUNQ, 0, 0), 0);
    end
    for (int p = 0; p < 2; p++)
      for (int o = 0; o < 2; o++) begin
        dig(4'h3 << (2 * p), o << p);
        ev_q.push_back(8'h1 << (2 * p + o));
        trig();
        ev_q.push_back(8'h1 << (2 * p + 1 - o));
        trig();
        rd(`SAC_REG_STATE, 32'h0, 32'h1);
        q(c(`SAC_OP_STATQ, 3 - 2 * p, `SAC_CLS_CHAN), 0);
        q(c(`SAC_OP_STATQ, 1 + 2 * p, `SAC_CLS_CHAN), 1);
      end
    for (int k = 0; k < 4; k++) begin
      ch = (k[0] ? 8'h1 : 8'h2) | (k[1] ? 8'h4 : 8'h8);
      dig(ch[3:0], 2'h0);
      ev_q.push_back(ch);
      trig();
    end
    dig(4'h1, 2'h0);
    cmd(c(`SAC_OP_CLEAR, 0, 0));
    trig();
    rd(`SAC_REG_STATE, 32'h8, 32'h8);
    for (int m = 0; m < 2; m++) begin
      sweep_mode_setting_i <= m[1:0];
      cmd(c(`SAC_OP_RUN, 0, 0));
      ev_q.push_back(8'h01);
      trig();
      if (m) ev_q.push_back(8'h01);
      trig();
      cmd(c(`SAC_OP_STOP, 0, 0));
    end
    ev_q.push_back(8'h10);
    fail();
    fail();
    q(c(`SAC_OP_LTERQ, 0, 0), 1);
    q(c(`SAC_OP_LTERQ, 0, 0), 0);
    ev_q.push_back(8'h10);
    fail();
    for (int s = 0; s < 2; s++) begin
      protect_open_i <= s[0];
      repeat (4) @(posedge clk_i);
      ev_q.push_back(s ? 8'h40 : 8'h20);
      for (int i = 0; i < 10; i++) begin
        ch = $urandom % 36;
        ch = (ch < 8'd10) ? 8'h30 + ch : 8'h37 + ch;
        cmd({ch, 20'h0, `SAC_OP_SERIAL});
      end
      settle();
    end
    rd(`SAC_REG_IDN, {24'h0, ch}, 32'hFF);
    q(c(`SAC_OP_IDNQ, 0, 0), `SAC_ID_CODE);
    ev_q.push_back(8'h20);
    cmd(c(`SAC_OP_ERASE, 3, `SAC_CLS_PMEM));
    ev_q.push_back(8'h20);
    cmd(c(`SAC_OP_MERGE, 0, `SAC_CLS_PMEM));
    settle();
    cmd(c(`SAC_OP_ERASE, 1, `SAC_CLS_PMEM));
    rd(`SAC_REG_STATE, 32'h10, 32'h10);
    ev_q.push_back(8'h20);
    cmd(c(`SAC_OP_ERASE, 2, `SAC_CLS_PMEM));
    repeat (20) @(posedge clk_i);
    rd(`SAC_REG_STATE, 32'h0, 32'h10);
    ch = $urandom % 16;
    wr(`SAC_REG_MEMADDR, {26'h0, 2'h1, ch[3:0]});
    rd(`SAC_REG_MEMWORD, 32'h0, 32'hFF);
    cmd(c(`SAC_OP_MERGE, 2, `SAC_CLS_PMEM));
    repeat (20) @(posedge clk_i);
    rd(`SAC_REG_STATE, 32'h0, 32'h10);
    cmd(c(`SAC_OP_RUN, 0, 0));
    cmd(c(`SAC_OP_ERASE, 0, `SAC_CLS_PMEM));
    repeat (20) @(posedge clk_i);
    rd(`SAC_REG_STATE, 32'h1, 32'h11);
    wr(`SAC_REG_MEMADDR, {26'h0, 2'h0, ch[3:0]});
    rd(`SAC_REG_MEMWORD, 32'h0, 32'hFF);
    cmd(c(`SAC_OP_STOP, 0, 0));
    settle();
    stop_test();
  end
endmodule // tb_sac_top
